// >>> rtl/flash_host_pkg.sv
// Constants shared by the flash query host controller.
package flash_host_pkg;
  localparam logic [7:0]  CMD_QUERY       = 8'h98;
  localparam logic [7:0]  CMD_RESET       = 8'hF0;
  localparam logic [7:0]  CMD_AUTOSELECT  = 8'h90;
  localparam logic [7:0]  CMD_UNLOCK1     = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
  localparam logic [20:0] ADDR_QUERY      = 21'h000055;
  localparam logic [20:0] ADDR_UNLOCK1    = 21'h000555;
  localparam logic [20:0] ADDR_UNLOCK2    = 21'h0002AA;
  localparam logic [7:0]  QUERY_FIRST     = 8'h10;
  localparam logic [7:0]  QUERY_LAST      = 8'h4C;
  localparam int          QUERY_WORDS     = 64;
  localparam logic [7:0]  MARK_Q          = 8'h51;
  localparam logic [7:0]  MARK_R          = 8'h52;
  localparam logic [7:0]  MARK_Y          = 8'h59;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_ADDR        = 8'h08;
  localparam logic [7:0]  OFS_WDATA       = 8'h0C;
  localparam logic [7:0]  OFS_RDATA       = 8'h10;
  localparam logic [7:0]  OFS_TABLE       = 8'h14;
  localparam logic [7:0]  OFS_TDATA       = 8'h18;
  localparam int          CTRL_GO         = 0;
  localparam int          CTRL_OP_LSB     = 1;
  localparam logic [2:0]  OP_READ         = 3'h0;
  localparam logic [2:0]  OP_WRITE        = 3'h1;
  localparam logic [2:0]  OP_QUERY        = 3'h2;
  localparam logic [2:0]  OP_RESET        = 3'h3;
  localparam logic [2:0]  OP_AUTOSELECT   = 3'h4;
  localparam logic [2:0]  OP_DUMP         = 3'h5;
  localparam int          T_SETUP_NS      = 40;
  localparam int          T_PULSE_NS      = 80;
  localparam int          CLK_NS          = 10;
  localparam logic [3:0]  SETUP_CYC       = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  PULSE_CYC       = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// >>> rtl/query_store.sv
// Small memory that keeps the query bytes read back from the flash.
`timescale 1ns/1ps
`default_nettype none
module query_store (
  input  wire logic       aclk,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr,
  output var  logic [7:0] rdata
);
  logic [7:0] mem [0:63];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> rtl/flash_query_host.sv
// Host controller that drives the flash bus pins and dumps the query table.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Writing 98h to address 55h from array read enters query mode.
// - Reset command leaves query mode back to array reads.
// - Query also works from identifier mode; reset then returns there.
// - Host issues reset only when software requests OP_RESET; the timeout flag and identifier mode are only reported.
module flash_query_host
  import flash_host_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [20:0]      flash_addr,
  input  wire logic [7:0]  flash_dq_in,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_PULSE = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_READ  = 5'b10000
  } bus_state_e;

  bus_state_e  state;
  logic [2:0]  op;
  logic        busy;
  logic        timeout_flag_bit;
  logic        in_query;
  logic        in_ident;
  logic        from_ident;
  logic        dump_done;
  logic        marker_ok;
  logic [3:0]  cnt;
  logic [2:0]  step;
  logic [5:0]  dump_idx;
  logic [20:0] user_addr;
  logic [7:0]  user_wdata;
  logic [7:0]  rd_byte;
  logic [5:0]  table_idx;
  logic [7:0]  table_byte;
  logic [2:0]  dq_sync;
  logic        cyc_write;
  logic [20:0] cyc_addr;
  logic [7:0]  cyc_data;
  logic [2:0]  nsteps;
  logic        go;
  logic        aw_ok;
  logic        w_ok;
  logic        wr_fire;
  logic        store_we;

  // Write address and data are taken only together, in a cycle where both are valid and no response is pending; nothing is held.
  assign s_axi_awready = !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign aw_ok         = (s_axi_awaddr == OFS_CTRL) || (s_axi_awaddr == OFS_ADDR) ||
                         (s_axi_awaddr == OFS_WDATA) || (s_axi_awaddr == OFS_TABLE);
  assign w_ok          = s_axi_wstrb[0];
  assign go            = wr_fire && aw_ok && (s_axi_awaddr == OFS_CTRL) && s_axi_wdata[CTRL_GO] && !busy && w_ok;
  assign busy          = (state != ST_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_addr  <= 21'h000000;
      user_wdata <= 8'h00;
      table_idx  <= 6'h00;
      op         <= OP_READ;
    end else if (wr_fire && w_ok) begin
      if (s_axi_awaddr == OFS_ADDR) begin
        user_addr <= s_axi_wdata[20:0];
      end
      if (s_axi_awaddr == OFS_WDATA) begin
        user_wdata <= s_axi_wdata[7:0];
      end
      if (s_axi_awaddr == OFS_TABLE) begin
        table_idx <= s_axi_wdata[5:0];
      end
      if (go) begin
        op <= s_axi_wdata[CTRL_OP_LSB +: 3];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:   s_axi_rdata <= {28'h0000000, op, 1'b0};
        OFS_STATUS: s_axi_rdata <= {26'h0000000, marker_ok, dump_done, from_ident, in_ident, in_query, busy};
        OFS_ADDR:   s_axi_rdata <= {11'h000, user_addr};
        OFS_WDATA:  s_axi_rdata <= {24'h000000, user_wdata};
        OFS_RDATA:  s_axi_rdata <= {23'h000000, timeout_flag_bit, rd_byte};
        OFS_TABLE:  s_axi_rdata <= {26'h0000000, table_idx};
        OFS_TDATA:  s_axi_rdata <= {24'h000000, table_byte};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin data pass three flops; a byte counts once the last two stages agree.
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic [7:0] dq_s3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end
  assign dq_sync = {2'b00, dq_s2 == dq_s3};

  // Sequence steps per operation; unlock cycles precede the identifier command.
  always_comb begin
    cyc_write = 1'b1;
    cyc_addr  = user_addr;
    cyc_data  = user_wdata;
    nsteps    = 3'd1;
    unique case (op)
      OP_WRITE: begin
        cyc_addr = user_addr;
      end
      OP_QUERY: begin
        cyc_addr = ADDR_QUERY;
        cyc_data = CMD_QUERY;
      end
      OP_RESET: begin
        cyc_addr = user_addr;
        cyc_data = CMD_RESET;
      end
      OP_AUTOSELECT: begin
        nsteps = 3'd3;
        cyc_addr = (step == 3'd0) ? ADDR_UNLOCK1 : (step == 3'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
        cyc_data = (step == 3'd0) ? CMD_UNLOCK1 : (step == 3'd1) ? CMD_UNLOCK2 : CMD_AUTOSELECT;
      end
      OP_DUMP: begin
        cyc_write = 1'b0;
        cyc_addr  = {13'h0000, QUERY_FIRST + {2'b00, dump_idx}};
      end
      default: begin
        cyc_write = 1'b0;
      end
    endcase
  end

  // Select falls first and rises last, so the strobe edges set the latch points.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= ST_IDLE;
      cnt          <= 4'h0;
      step         <= 3'd0;
      dump_idx     <= 6'h00;
      flash_addr   <= 21'h000000;
      flash_dq_out <= 8'h00;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          step     <= 3'd0;
          dump_idx <= 6'h00;
          if (go) begin
            state <= ST_SETUP;
            cnt   <= 4'h0;
          end
        end
        ST_SETUP: begin
          flash_addr   <= cyc_addr;
          flash_dq_out <= cyc_data;
          flash_dq_oe  <= cyc_write;
          flash_ce_n   <= 1'b0;
          cnt          <= cnt + 4'h1;
          if (cnt == SETUP_CYC) begin
            cnt        <= 4'h0;
            flash_we_n <= !cyc_write;
            flash_oe_n <= cyc_write;
            state      <= cyc_write ? ST_PULSE : ST_READ;
          end
        end
        ST_PULSE: begin
          cnt <= cnt + 4'h1;
          if (cnt == PULSE_CYC) begin
            flash_we_n <= 1'b1;
            cnt        <= 4'h0;
            state      <= ST_HOLD;
          end
        end
        ST_READ: begin
          cnt <= cnt + 4'h1;
          if (cnt >= PULSE_CYC && dq_sync[0]) begin
            flash_oe_n <= 1'b1;
            cnt        <= 4'h0;
            state      <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          cnt         <= 4'h0;
          if (op == OP_DUMP && dump_idx != 6'(QUERY_LAST - QUERY_FIRST)) begin
            dump_idx <= dump_idx + 6'h01;
            state    <= ST_SETUP;
          end else if (step + 3'd1 < nsteps) begin
            step  <= step + 3'd1;
            state <= ST_SETUP;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign store_we = (state == ST_READ) && (cnt >= PULSE_CYC) && dq_sync[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_byte          <= 8'h00;
      timeout_flag_bit <= 1'b0;
    end else if (store_we) begin
      rd_byte          <= dq_s3;
      timeout_flag_bit <= dq_s3[5] && (op == OP_READ);
    end
  end

  // Mode tracking mirrors the device so software knows where a reset lands.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_query   <= 1'b0;
      in_ident   <= 1'b0;
      from_ident <= 1'b0;
      dump_done  <= 1'b0;
      marker_ok  <= 1'b0;
    end else begin
      if (go) begin
        dump_done <= 1'b0;
      end
      if (state == ST_HOLD && step + 3'd1 >= nsteps) begin
        unique case (op)
          OP_QUERY: begin
            in_query   <= 1'b1;
            from_ident <= in_ident;
          end
          OP_RESET: begin
            in_query <= 1'b0;
            in_ident <= in_query && from_ident;
          end
          OP_AUTOSELECT: begin
            in_ident <= !in_query;
          end
          OP_WRITE: begin
            in_query <= 1'b0;
            in_ident <= 1'b0;
          end
          OP_DUMP: begin
            dump_done <= (dump_idx == 6'(QUERY_LAST - QUERY_FIRST));
          end
          default: begin
          end
        endcase
      end
      if (store_we && op == OP_DUMP) begin
        if (dump_idx == 6'h00) begin
          marker_ok <= (dq_s3 == MARK_Q);
        end else if (dump_idx == 6'h01 || dump_idx == 6'h02) begin
          marker_ok <= marker_ok && (dq_s3 == ((dump_idx == 6'h01) ? MARK_R : MARK_Y));
        end
      end
    end
  end

  query_store u_store (
    .aclk  (aclk),
    .we    (store_we && op == OP_DUMP),
    .waddr (dump_idx),
    .wdata (dq_s3),
    .raddr (table_idx),
    .rdata (table_byte)
  );
endmodule
`default_nettype wire

// >>> verification/flash_query_host_checker.sv
// Concurrent checks on the flash pins and bus answers of the query host.
`timescale 1ns/1ps
`default_nettype none
module flash_query_host_checker
  import flash_host_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  input  wire logic [20:0] flash_addr,
  input  wire logic [7:0]  flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_under_select: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("Write strobe low without select, with output enable, or without data drive.");
  // The device takes data at the strobe's rise, so both must hold through the pulse.
  a_data_steady_pulse: assert property (!flash_we_n |=> flash_we_n || ($stable(flash_dq_out) && $stable(flash_addr)))
    else $error("Address or data moved during the write pulse.");
  a_pulse_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*8] ##[1:12] flash_we_n)
    else $error("Write pulse too short or never ends.");
  a_select_drops: assert property ($rose(flash_we_n) |-> ##[0:8] flash_ce_n)
    else $error("Select not released after a write cycle.");
  a_no_contention: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("Host drives the data lines during a read.");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("Write response late.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read response late.");
  a_error_data_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("Refused read returns nonzero data.");
endmodule
bind flash_query_host flash_query_host_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
);
`default_nettype wire

// >>> verification/flash_dev_model.sv
// Behavioural model of the byte-wide flash command front end and its query table.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int         ACC_NS     = 60,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'hC3  // Arbitrary value.
) (
  input  wire logic [20:0] addr,
  input  wire logic [7:0]  host_dq,
  input  wire logic        host_dq_oe,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  output wire logic [7:0]  dq
);
  localparam logic [255:0] TQ_LO = 256'h51525902004000000000002736000004000A00050004001500000000011F0000;
  localparam logic [231:0] TQ_HI = 232'h0100000000000080000000000000000050524931300102010104000000;
  logic [1:0]  mode    = 2'd0;
  logic        from_id = 1'b0;
  logic [1:0]  ul      = 2'd0;
  logic [20:0] la;
  logic [7:0]  last    = 8'h00;
  logic [7:0]  rd_val;
  wire         wr_n    = ce_n | we_n;
  wire         drv     = !ce_n && !oe_n && we_n;
  wire  [7:0]  bus     = host_dq_oe ? host_dq : (drv ? rd_val : ~last);
  function automatic logic [7:0] qbyte(input logic [7:0] a);
    if (a >= 8'h10 && a <= 8'h2F) return TQ_LO[8*(8'h2F-a) +: 8];
    if (a >= 8'h30 && a <= 8'h4C) return TQ_HI[8*(8'h4C-a) +: 8];
    return 8'h00;
  endfunction
  function automatic logic [7:0] arr(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  always_comb begin
    if (mode == 2'd2) rd_val = qbyte(addr[7:0]);
    else if (mode == 2'd1) rd_val = (addr[7:0] == 8'h00) ? MAKER_CODE : (addr[7:0] == 8'h01) ? PART_CODE : 8'h00;
    else rd_val = arr(addr);
  end
  // A released bus shows the inverse of the last value, so stale data never passes.
  assign #(ACC_NS) dq = bus;
  always @(posedge oe_n) last <= rd_val;
  always @(negedge wr_n) la <= addr;
  always @(posedge wr_n) begin
    if (bus == 8'hF0) begin
      mode <= (mode == 2'd2 && from_id) ? 2'd1 : 2'd0;
      ul <= 2'd0;
    end else if (bus == 8'h98 && la[7:0] == 8'h55 && mode != 2'd2) begin
      from_id <= (mode == 2'd1);
      mode <= 2'd2;
      ul <= 2'd0;
    end else if (ul == 2'd0 && bus == 8'hAA && la[10:0] == 11'h555) ul <= 2'd1;
    else if (ul == 2'd1 && bus == 8'h55 && la[10:0] == 11'h2AA) ul <= 2'd2;
    else if (ul == 2'd2 && bus == 8'h90 && la[10:0] == 11'h555) begin
      mode <= 2'd1;
      ul <= 2'd0;
    end else begin
      mode <= 2'd0;
      ul <= 2'd0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Register-level testbench of the flash query host with a flash model behind it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] PART  = 8'hC3;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, last_st;
  logic [20:0] flash_addr;
  logic [7:0]  flash_dq_in, flash_dq_out;
  logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  int          error_cnt = 0;
  int          cmp_count = 0;
  flash_query_host DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
  );
  flash_dev_model #(.ACC_NS(60), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
    .addr(flash_addr), .host_dq(flash_dq_out), .host_dq_oe(flash_dq_oe), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .dq(flash_dq_in)
  );
  always #5 aclk = ~aclk;
  task automatic conclude();
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Runs one flash operation and keeps the status seen once busy clears.
  task automatic op(input logic [2:0] c, input logic [20:0] a);
    logic [1:0] r;
    wr(OFS_ADDR, {11'h0, a}, r);
    wr(OFS_CTRL, {28'h0, c, 1'b1}, r);
    last_st = 32'h1;
    while (last_st[0] !== 1'b0) rd(OFS_STATUS, last_st, r);
  endtask
  task automatic stat(input logic [2:0] e);
    chk({29'h0, last_st[3:1]}, {29'h0, e});
  endtask
  task automatic rdb(input logic [20:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    op(OP_READ, a);
    rd(OFS_RDATA, d, r);
    chk({24'h0, d[7:0]}, {24'h0, e});
    chk({31'h0, d[8]}, {31'h0, e[5]});
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdb(21'h012345, u_flash.arr(21'h012345));
    op(OP_QUERY, ADDR_QUERY);
    op(OP_DUMP, 21'h0);
    chk({30'h0, last_st[5:4]}, 32'h3);
    for (int i = 0; i <= 60; i++) begin
      wr(OFS_TABLE, 32'(i), r);
      rd(OFS_TDATA, d, r);
      chk({24'h0, d[7:0]}, {24'h0, u_flash.qbyte(8'(16 + i))});
    end
    op(OP_RESET, 21'h0);
    op(OP_QUERY, ADDR_QUERY);
    stat(3'b001);
    rdb(21'h10, 8'h51);
    rdb(21'h11, 8'h52);
    rdb(21'h12, 8'h59);
    op(OP_RESET, 21'h1FFFFF);
    stat(3'b000);
    rdb(21'h000777, u_flash.arr(21'h000777));
    op(OP_QUERY, ADDR_QUERY);
    wr(OFS_WDATA, 32'h12, r);
    op(OP_WRITE, 21'h0);
    s_axi_wstrb <= 4'hE;
    wr(OFS_WDATA, 32'h77, r);
    s_axi_wstrb <= 4'hF;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_WDATA, d, r);
    chk(d, 32'h12);
    rdb(21'h1A0B0C, u_flash.arr(21'h1A0B0C));
    op(OP_AUTOSELECT, 21'h0);
    stat(3'b010);
    rdb(21'h0, MAKER);
    rdb(21'h1, PART);
    rdb(21'h0A0002, 8'h00);
    op(OP_QUERY, ADDR_QUERY);
    stat(3'b111);
    rdb(21'h10, 8'h51);
    op(OP_RESET, 21'h0);
    rdb(21'h0, MAKER);
    op(OP_RESET, 21'h0);
    rdb(21'h000321, u_flash.arr(21'h000321));
    rd(8'h1C, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h1C, 32'h5, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    conclude();
  end
endmodule
`default_nettype wire
